// File: scw_map.svh
`ifndef SCW_MAP_SVH
`define SCW_MAP_SVH

// register bus
`define SCW_ADDR_W        8
`define SCW_CFG_IDX       6
`define SCW_CFG_ADDR      (`SCW_CFG_IDX * 4)
`define SCW_CTRL_ADDR     8'h40
`define SCW_STAT_ADDR     8'h44
`define SCW_RESP_OKAY     2'b00
`define SCW_RESP_SLVERR   2'b10

// configuration word
`define SCW_CFG_W         28
`define SCW_CFG_RESET     28'h0000000
`define SCW_CTRL_RESET    32'h00000001
`define SCW_BIT_TERM      12
`define SCW_BIT_BYPASS_LO 13
`define SCW_BIT_PUMP_LO   16
`define SCW_BIT_ALIGN     20
`define SCW_BIT_WIDE      21
`define SCW_BIT_CAL       22
`define SCW_BIT_AUX_ON    24
`define SCW_BIT_AUX_SRC   25
`define SCW_BIT_EXT_LF    26
`define SCW_BIT_MANUAL    27
`define SCW_BIT_SYNC_CTRL 0

// pin synchroniser reset levels: sync pin idles high
`define SCW_PIN_RESET     4'h1

// calibration timing
`define SCW_CLK_NS        25
`define SCW_CAL_TIME_NS   10000
`define SCW_CAL_CYCLES    ((`SCW_CAL_TIME_NS + `SCW_CLK_NS - 1) / `SCW_CLK_NS)

`endif

// File: scw_pkg.sv
`default_nettype none

package scw_pkg;

  typedef struct packed {
    logic       vco_cal_manual;
    logic       external_filter_sel;
    logic       aux_source_sel;
    logic       aux_out_on;
    logic       rsv23;
    logic       vco_cal_request;
    logic       pump_wide_pulse;
    logic       output_align_mode;
    logic [3:0] pump_current;
    logic [2:0] bypass_div;
    logic       secondary_term_disable;
    logic       rsv11;
    logic       feedback_div_bit7;
    logic [9:0] lower_fields;
  } scw_cfg_t;

  typedef struct packed {
    logic [14:0] rsv_hi;
    logic        align_pending;
    logic [7:0]  cal_count;
    logic [5:0]  rsv_lo;
    logic        startup_done;
    logic        cal_busy;
  } scw_stat_t;

  typedef enum logic {
    SCW_CAL_IDLE,
    SCW_CAL_RUN
  } scw_cal_state_t;

endpackage

`default_nettype wire

// File: scw_sync2.sv
`include "scw_map.svh"
`default_nettype none

module scw_sync2 #(
  parameter int           W  = 4,
  parameter logic [W-1:0] RV = '0
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // pins
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= RV;
      q    <= RV;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// File: scw_vco_cal.sv
`include "scw_map.svh"
`default_nettype none

module scw_vco_cal
  import scw_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // control
  input  wire logic       cal_edge,
  input  wire logic       manual,
  // state
  output logic            busy,
  output logic            startup_done,
  output logic      [7:0] count
);

  scw_cal_state_t state;
  logic [15:0]    timer;
  logic           boot_pending;
  logic           boot_run;
  logic           start_manual;
  logic           start_boot;
  logic           finish;

  assign start_manual = cal_edge && manual && (state == SCW_CAL_IDLE);
  assign start_boot   = boot_pending && !manual && (state == SCW_CAL_IDLE);
  assign finish       = (state == SCW_CAL_RUN) && (timer == 16'h0001);
  assign busy         = (state == SCW_CAL_RUN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SCW_CAL_IDLE;
    end else begin
      unique case (state)
        SCW_CAL_IDLE: if (start_manual || start_boot) state <= SCW_CAL_RUN;
        SCW_CAL_RUN:  if (finish) state <= SCW_CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer <= 16'h0000;
    end else if (start_manual || start_boot) begin
      timer <= 16'(`SCW_CAL_CYCLES);
    end else if (timer != 16'h0000) begin
      timer <= timer - 16'h0001;
    end
  end

  // startup window closes at first idle cycle, manual mode skips it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_pending <= 1'b1;
      boot_run     <= 1'b0;
      startup_done <= 1'b0;
    end else begin
      if (state == SCW_CAL_IDLE) boot_pending <= 1'b0;
      if (start_boot) boot_run <= 1'b1;
      else if (finish) boot_run <= 1'b0;
      if (finish && boot_run) startup_done <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 8'h00;
    end else if (finish) begin
      count <= count + 8'h01;
    end
  end

endmodule

`default_nettype wire

// File: scw_config_top.sv
`include "scw_map.svh"
`default_nettype none

// Function
// - bit 12 high turns the secondary input termination off
// - bits 13 to 15 hold the three-bit bypass divider code
// - bits 16 to 19 hold the four-bit charge pump current code
// - align mode 0: align outputs on reference edge after sync release
// - align mode 1: align outputs directly on sync release
// - bit 21 picks wide (1) or narrow (0) pump pulse
// - a rising edge of bit 22, not its level, is the request
// - the request starts calibration only in manual mode
// - bit 27 low selects startup calibration mode
// - auxiliary output is driven only while bit 24 is 1
// - bit 25 routes output divider 2 (0) or 3 (1) to aux
// - bit 26 selects external (1) or internal (0) loop filter
module scw_config_top
  import scw_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address
  input  wire logic  [7:0] s_axi_awaddr,
  input  wire logic  [2:0] s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic  [3:0] s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response
  output logic       [1:0] s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address
  input  wire logic  [7:0] s_axi_araddr,
  input  wire logic  [2:0] s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // read data
  output logic      [31:0] s_axi_rdata,
  output logic       [1:0] s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins and divider taps
  input  wire logic        sync_n_pin,
  input  wire logic        ref_clk_in,
  input  wire logic        out_div2_clk,
  input  wire logic        out_div3_clk,
  // analog control
  output var scw_cfg_t     cfg_word,
  output logic             secondary_term_enable,
  output logic             vco_cal_active,
  output logic             output_align_pulse,
  output logic             aux_out_en,
  output logic             aux_clk_out
);

  logic  [7:0] aw_addr;
  logic        aw_full;
  logic [31:0] w_data;
  logic  [3:0] w_strb;
  logic        w_full;
  logic        do_write;
  logic        cfg_hit;
  logic        ctrl_hit;
  logic        stat_hit;
  logic [31:0] ctrl;
  logic [31:0] next_cfg32;
  logic [31:0] next_ctrl;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic  [3:0] pin_s;
  logic        sync_eff_n;
  logic        sync_prev_n;
  logic        sync_rise;
  logic        ref_prev;
  logic        ref_rise;
  logic        align_pending;
  logic        cal_prev;
  logic        cal_edge;
  logic        cal_startup_done;
  logic  [7:0] cal_count;
  scw_stat_t   stat;

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic  [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = data[8*i +: 8];
    end
    return res;
  endfunction

  // write channel: address and data may come in either order
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign do_write      = aw_full && w_full && !s_axi_bvalid;
  assign cfg_hit  = ({aw_addr[7:2], 2'b00} == 8'(`SCW_CFG_ADDR));
  assign ctrl_hit = ({aw_addr[7:2], 2'b00} == `SCW_CTRL_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SCW_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (cfg_hit || ctrl_hit) ? `SCW_RESP_OKAY
                                            : `SCW_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign next_cfg32 = merge_bytes({4'h0, cfg_word}, w_data, w_strb);
  assign next_ctrl  = merge_bytes(ctrl, w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_word <= scw_cfg_t'(`SCW_CFG_RESET);
    end else if (do_write && cfg_hit) begin
      cfg_word <= scw_cfg_t'(next_cfg32[`SCW_CFG_W-1:0]);
    end
  end

  // only the sync control bit is kept; the rest reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `SCW_CTRL_RESET;
    end else if (do_write && ctrl_hit) begin
      ctrl <= {31'h00000000, next_ctrl[`SCW_BIT_SYNC_CTRL]};
    end
  end

  assign secondary_term_enable = !cfg_word.secondary_term_disable;

  // read channel: one beat at a time
  assign s_axi_arready = !s_axi_rvalid;
  assign stat_hit = ({s_axi_araddr[7:2], 2'b00} == `SCW_STAT_ADDR);

  always_comb begin
    stat               = '0;
    stat.cal_busy      = vco_cal_active;
    stat.startup_done  = cal_startup_done;
    stat.cal_count     = cal_count;
    stat.align_pending = align_pending;
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    if ({s_axi_araddr[7:2], 2'b00} == 8'(`SCW_CFG_ADDR)) begin
      rd_word = {4'h0, cfg_word};
    end else if ({s_axi_araddr[7:2], 2'b00} == `SCW_CTRL_ADDR) begin
      rd_word = ctrl;
    end else if (stat_hit) begin
      rd_word = stat;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `SCW_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `SCW_RESP_OKAY : `SCW_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  scw_sync2 #(
    .W  (4),
    .RV (`SCW_PIN_RESET)
  ) u_pins (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({out_div3_clk, out_div2_clk, ref_clk_in, sync_n_pin}),
    .q       (pin_s)
  );

  // pin and control bit both act as the active-low sync
  assign sync_eff_n = pin_s[0] && ctrl[`SCW_BIT_SYNC_CTRL];
  assign sync_rise  = sync_eff_n && !sync_prev_n;
  assign ref_rise   = pin_s[1] && !ref_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_prev_n <= 1'b1;
      ref_prev    <= 1'b0;
    end else begin
      sync_prev_n <= sync_eff_n;
      ref_prev    <= pin_s[1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      align_pending <= 1'b0;
    end else if (sync_rise && !cfg_word.output_align_mode) begin
      align_pending <= 1'b1;
    end else if (ref_rise || !sync_eff_n
                 || cfg_word.output_align_mode) begin
      align_pending <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_align_pulse <= 1'b0;
    end else if (cfg_word.output_align_mode) begin
      output_align_pulse <= sync_rise;
    end else begin
      output_align_pulse <= align_pending && ref_rise && sync_eff_n;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_prev <= 1'b0;
    end else begin
      cal_prev <= cfg_word.vco_cal_request;
    end
  end

  assign cal_edge = cfg_word.vco_cal_request && !cal_prev;

  // an edge during a running calibration is dropped, not queued
  scw_vco_cal u_cal (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .cal_edge     (cal_edge),
    .manual       (cfg_word.vco_cal_manual),
    .busy         (vco_cal_active),
    .startup_done (cal_startup_done),
    .count        (cal_count)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_out_en  <= 1'b0;
      aux_clk_out <= 1'b0;
    end else begin
      aux_out_en  <= cfg_word.aux_out_on;
      aux_clk_out <= cfg_word.aux_out_on
                     && (cfg_word.aux_source_sel ? pin_s[3] : pin_s[2]);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_term_disable: assert property (
    do_write && cfg_hit && w_strb[1] && w_data[`SCW_BIT_TERM]
    |=> cfg_word.secondary_term_disable && !secondary_term_enable)
    else $error("termination not disabled");

  a_term_enable: assert property (
    do_write && cfg_hit && w_strb[1] && !w_data[`SCW_BIT_TERM]
    |=> secondary_term_enable)
    else $error("termination not enabled");

  a_bypass_field: assert property (
    do_write && cfg_hit && w_strb[1]
    |=> cfg_word.bypass_div == $past(w_data[15:13]))
    else $error("bypass code mismatch");

  a_pump_current: assert property (
    do_write && cfg_hit && w_strb[2]
    |=> cfg_word.pump_current == $past(w_data[19:16]))
    else $error("pump current mismatch");

  a_align_ref: assert property (
    output_align_pulse && !$past(cfg_word.output_align_mode)
    |-> $past(ref_rise) && $past(align_pending))
    else $error("align without reference edge");

  a_align_direct: assert property (
    sync_rise && cfg_word.output_align_mode |=> output_align_pulse)
    else $error("direct align missing");

  a_pulse_width: assert property (
    do_write && cfg_hit && w_strb[2]
    |=> cfg_word.pump_wide_pulse == $past(w_data[`SCW_BIT_WIDE]))
    else $error("pulse width mismatch");

  a_cal_level: assert property (
    !vco_cal_active && !cal_edge && cfg_word.vco_cal_manual
    |=> !vco_cal_active)
    else $error("calibration started without edge");

  a_cal_manual: assert property (
    cal_edge && cfg_word.vco_cal_manual && !vco_cal_active
    |=> vco_cal_active [*8])
    else $error("manual calibration not started");

  a_cal_startup: assert property (
    !vco_cal_active && !cfg_word.vco_cal_manual && cal_startup_done
    |=> !vco_cal_active)
    else $error("startup calibration repeated");

  a_aux_off: assert property (
    !cfg_word.aux_out_on |=> !aux_out_en && !aux_clk_out)
    else $error("aux driven while off");

  a_aux_source: assert property (
    cfg_word.aux_out_on && !cfg_word.aux_source_sel
    |=> aux_clk_out == $past(pin_s[2]))
    else $error("aux source wrong");

  a_ext_filter: assert property (
    do_write && cfg_hit && w_strb[3]
    |=> cfg_word.external_filter_sel == $past(w_data[`SCW_BIT_EXT_LF]))
    else $error("loop filter select mismatch");

  c_manual_cal: cover property (
    cal_edge && cfg_word.vco_cal_manual ##1 vco_cal_active);
  c_align_ref: cover property (
    output_align_pulse && !cfg_word.output_align_mode);
  c_align_direct: cover property (
    output_align_pulse && cfg_word.output_align_mode);
  c_cfg_write: cover property (do_write && cfg_hit);

endmodule

`default_nettype wire

// File: scw_config_top_test.sv
`include "scw_map.svh"
`default_nettype none

module scw_config_top_test
  import scw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] CFG_A = 8'(`SCW_CFG_ADDR);
  localparam int         CAL_N = `SCW_CAL_CYCLES;

  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        sync_n_pin, ref_clk_in, out_div2_clk, out_div3_clk;
  scw_cfg_t    cfg_word;
  logic        secondary_term_enable, vco_cal_active, output_align_pulse;
  logic        aux_out_en, aux_clk_out;
  logic [27:0] cfg_exp;
  logic [31:0] rng, rd, d;
  int          fails, tests_run, cycles, n;

  scw_config_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sync_n_pin(sync_n_pin),
    .ref_clk_in(ref_clk_in), .out_div2_clk(out_div2_clk),
    .out_div3_clk(out_div3_clk), .cfg_word(cfg_word),
    .secondary_term_enable(secondary_term_enable),
    .vco_cal_active(vco_cal_active),
    .output_align_pulse(output_align_pulse),
    .aux_out_en(aux_out_en), .aux_clk_out(aux_clk_out)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  function logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function logic [27:0] merge(input logic [27:0] old, input logic [31:0] v,
                              input logic [3:0] s);
    logic [31:0] r;
    r = {4'h0, old};
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = v[8*i +: 8];
    end
    return r[27:0];
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // readies are read at the falling edge, settled for the next rise
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                           input logic [3:0] s, output logic [1:0] r);
    logic aw_ok, w_ok, aw_t, w_t, b;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t  = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_t) begin
        s_axi_awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (w_t) begin
        s_axi_wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] r);
    logic t, ok;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ok = s_axi_rvalid;
      v  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge aclk);
    end while (!ok);
    s_axi_rready <= 1'b0;
  endtask

  task automatic cfg_write(input logic [31:0] v);
    logic [1:0] r;
    axi_write(CFG_A, v, 4'hf, r);
    cfg_exp = v[27:0];
  endtask

  // counts falling edges until the chosen output reaches lvl, lim at most
  task automatic wait_sig(input bit sel, input logic lvl, input int lim,
                          output int k);
    k = 0;
    while (k < lim) begin
      @(negedge aclk);
      if ((sel ? output_align_pulse : vco_cal_active) === lvl) break;
      k++;
    end
  endtask

  task automatic pulse_sync();
    @(posedge aclk);
    sync_n_pin <= 1'b0;
    repeat (5) @(posedge aclk);
    sync_n_pin <= 1'b1;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    {fails, tests_run, cycles} = '0;
    rng = 32'h0000002e;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, ref_clk_in} = '0;
    {out_div2_clk, out_div3_clk} = '0;
    sync_n_pin = 1'b1;
    cfg_exp = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    wait_sig(0, 1'b1, 10, n);
    check("startup cal start", 32'(n < 4), 1);
    wait_sig(0, 1'b0, 1000, n);
    check("startup cal length", n, CAL_N - 1);
    axi_read(CFG_A, rd, resp);
    check("cfg reset", rd, 32'h0);
    check("term on", secondary_term_enable, 1'b1);
    axi_read(8'(`SCW_CTRL_ADDR), rd, resp);
    check("ctrl reset", rd, `SCW_CTRL_RESET);
    // unmapped place: write ignored, read zero, both refused
    axi_write(8'h80, 32'hffffffff, 4'hf, resp);
    check("unmapped bresp", resp, `SCW_RESP_SLVERR);
    axi_read(8'h80, rd, resp);
    check("unmapped rdata", rd, 32'h0);
    check("unmapped rresp", resp, `SCW_RESP_SLVERR);
    for (int i = 0; i < 24; i++) begin
      rng = xorshift(rng);
      d   = rng;
      // reserved zero, bit 22 held low
      d   = d & 32'hff3ff7ff;
      rng = xorshift(rng);
      @(posedge aclk);
      out_div2_clk <= rng[0];
      out_div3_clk <= rng[1];
      axi_write(CFG_A, d, (i < 4) ? 4'hf : rng[7:4], resp);
      cfg_exp = merge(cfg_exp, d, (i < 4) ? 4'hf : rng[7:4]);
      // aux flops update on the response edge itself, so look later
      @(negedge aclk);
      check("cfg bresp", resp, `SCW_RESP_OKAY);
      check("cfg word", cfg_word, cfg_exp);
      check("term enable", secondary_term_enable, !cfg_exp[12]);
      check("aux enable", aux_out_en, cfg_exp[24]);
      check("aux clock", aux_clk_out, cfg_exp[24] &
            (cfg_exp[25] ? rng[1] : rng[0]));
      axi_read(CFG_A, rd, resp);
      check("cfg read", rd, {4'h0, cfg_exp});
    end
    cfg_write(32'h00100000);
    pulse_sync();
    wait_sig(1, 1'b1, 10, n);
    check("align direct", 32'(n < 6), 1);
    wait_sig(1, 1'b0, 1, n);
    check("align one cycle", n, 0);
    cfg_write(32'h0);
    pulse_sync();
    wait_sig(1, 1'b1, 10, n);
    check("align waits ref", n, 10);
    @(posedge aclk);
    ref_clk_in <= 1'b1;
    wait_sig(1, 1'b1, 8, n);
    check("align on ref", 32'(n < 6), 1);
    @(posedge aclk);
    ref_clk_in <= 1'b0;
    cfg_write(32'h00100000);
    axi_write(8'(`SCW_CTRL_ADDR), 32'h0, 4'hf, resp);
    wait_sig(1, 1'b1, 10, n);
    check("align held by bit", n, 10);
    axi_write(8'(`SCW_CTRL_ADDR), 32'h1, 4'hf, resp);
    wait_sig(1, 1'b1, 10, n);
    check("align by bit", 32'(n < 6), 1);
    cfg_write(32'h0);
    cfg_write(32'h00400000);
    wait_sig(0, 1'b1, 20, n);
    check("cal ignored startup", n, 20);
    // low then high in manual mode
    cfg_write(32'h08000000);
    cfg_write(32'h08400000);
    wait_sig(0, 1'b1, 10, n);
    check("cal manual start", 32'(n < 4), 1);
    wait_sig(0, 1'b0, 1000, n);
    check("cal manual length", n, CAL_N - 1);
    cfg_write(32'h08400000);
    wait_sig(0, 1'b1, 20, n);
    check("cal level ignored", n, 20);
    axi_read(8'(`SCW_STAT_ADDR), rd, resp);
    check("stat idle done", rd[1:0], 2'b10);
    check("cal count", rd[15:8], 8'h02);
    axi_write(8'(`SCW_STAT_ADDR), 32'h0, 4'hf, resp);
    check("stat read only", resp, `SCW_RESP_SLVERR);
    final_report();
  end
endmodule

`default_nettype wire
